// ==== dfc_defs.svh ====
// Constants for the decimation filter configuration block.
`ifndef DFC_DEFS_SVH
`define DFC_DEFS_SVH
`define DFC_ADDR_CTRL 8'h1B
`define DFC_ADDR_BAND 8'h1D
`define DFC_CTRL_RST 8'h00
`define DFC_BAND_RST 8'h00
`define DFC_CTRL_MASK 8'hBF
`define DFC_BAND_MASK 8'h03
`define DFC_ODD_BIT 3
`define DFC_DECEN_BIT 4
`define DFC_CSEL_BIT 5
`define DFC_OFFEN_BIT 7
`define DFC_RATIO_DEC2 3'h0
`define DFC_RATIO_DEC4 3'h1
`define DFC_RATIO_NONE 3'h2
`define DFC_RATIO_DEC8 3'h3
`define DFC_BAND_HP 2'h1
`define DFC_TAPS_EVEN 24
`define DFC_TAPS_ODD 23
`define DFC_FRAME_BITS 16
`define DFC_FIFO_DEPTH 8
`define DFC_SAMPLE_W 11
`define DFC_COEF_W 12
`define DFC_OUT_W 16
`define DFC_BI_LP2 12'h0AB
`define DFC_BI_LP4 12'h055
`endif

// ==== dfc_pkg.sv ====
// Types shared by the decimation filter configuration block.
package dfc_pkg;
  typedef enum logic [1:0] {st_idle, st_mac, st_out} dfc_state_t;
endpackage

// ==== dfc_ifs.sv ====
// Interfaces between the filter core, its serial port and its FIFO.
`timescale 1ns/1ns
`default_nettype none
interface dfc_cfg_if;
  logic wr;
  logic [7:0] addr;
  logic [7:0] data;
  modport src (output wr, output addr, output data);
  modport dst (input wr, input addr, input data);
endinterface

interface dfc_fifo_if #(parameter int W = 11);
  logic in_valid;
  logic in_ready;
  logic [W-1:0] in_data;
  logic out_valid;
  logic out_ready;
  logic [W-1:0] out_data;
  modport fifo (input in_valid, input in_data, input out_ready,
                output in_ready, output out_valid, output out_data);
  modport user (output in_valid, output in_data, output out_ready,
                input in_ready, input out_valid, input out_data);
endinterface
`default_nettype wire

// ==== dfc_fifo.sv ====
// Sample FIFO with a registered head word.
`timescale 1ns/1ns
`default_nettype none
`include "dfc_defs.svh"
module dfc_fifo
  import dfc_pkg::*;
#(
  parameter int W = `DFC_SAMPLE_W,
  parameter int DEPTH = `DFC_FIFO_DEPTH
) (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic reset_n,
  input wire logic clk_en,
  // Queue ports
  dfc_fifo_if.fifo q
);
  localparam int AW = $clog2(DEPTH);

  typedef struct packed {
    logic [DEPTH-1:0][W-1:0] mem;
    logic [AW-1:0] wp;
    logic [AW-1:0] rp;
    logic [AW:0] count;
    logic [W-1:0] head;
    logic head_v;
  } dfc_fifo_t;

  dfc_fifo_t r;
  dfc_fifo_t next_r;
  logic push;
  logic load;

  function automatic logic [AW-1:0] wrap_inc(input logic [AW-1:0] p);
    return (p == AW'(DEPTH - 1)) ? '0 : p + AW'(1);
  endfunction

  assign q.in_ready = (r.count != (AW+1)'(DEPTH));
  assign q.out_valid = r.head_v;
  assign q.out_data = r.head;

  always_comb begin
    next_r = r;
    push = q.in_valid && q.in_ready;
    load = (r.count != '0) && (!r.head_v || q.out_ready);
    if (push) begin
      next_r.mem[r.wp] = q.in_data;
      next_r.wp = wrap_inc(r.wp);
    end
    if (load) begin
      next_r.head = r.mem[r.rp];
      next_r.rp = wrap_inc(r.rp);
      next_r.head_v = 1'b1;
    end else if (q.out_ready) begin
      next_r.head_v = 1'b0;
    end
    next_r.count = r.count + (AW+1)'(push) - (AW+1)'(load);
  end

  always_ff @(posedge ref_clk) begin
    if (!reset_n) begin
      r <= '0;
    end else if (clk_en) begin
      r <= next_r;
    end
  end
endmodule
`default_nettype wire

// ==== dfc_serial_cfg.sv ====
// Serial configuration port that turns 16-bit frames into writes.
`timescale 1ns/1ns
`default_nettype none
`include "dfc_defs.svh"
module dfc_serial_cfg
  import dfc_pkg::*;
(
  // Clock and reset
  input wire logic ref_clk,
  input wire logic reset_n,
  input wire logic clk_en,
  // Serial pins
  input wire logic sclk,
  input wire logic sdata,
  input wire logic sen_n,
  // Register writes
  dfc_cfg_if.src cfg
);
  typedef struct packed {
    logic [2:0] sync1;
    logic [2:0] sync2;
    logic sclk_prev;
    logic [15:0] shift;
    logic [4:0] count;
    logic wr;
    logic [7:0] addr;
    logic [7:0] data;
  } dfc_ser_t;

  dfc_ser_t r;
  dfc_ser_t next_r;
  logic [15:0] word;

  assign cfg.wr = r.wr;
  assign cfg.addr = r.addr;
  assign cfg.data = r.data;

  // Bits beyond the sixteenth of a frame are ignored.
  always_comb begin
    next_r = r;
    word = {r.shift[14:0], r.sync2[1]};
    next_r.sync1 = {sclk, sdata, sen_n};
    next_r.sync2 = r.sync1;
    next_r.sclk_prev = r.sync2[2];
    next_r.wr = 1'b0;
    if (r.sync2[0]) begin
      next_r.count = '0;
    end else if (r.sync2[2] && !r.sclk_prev &&
                 r.count < 5'(`DFC_FRAME_BITS)) begin
      next_r.shift = word;
      next_r.count = r.count + 5'h1;
      if (r.count == 5'(`DFC_FRAME_BITS - 1)) begin
        next_r.wr = 1'b1;
        next_r.addr = word[15:8];
        next_r.data = word[7:0];
      end
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!reset_n) begin
      r <= '0;
    end else if (clk_en) begin
      r <= next_r;
    end
  end
endmodule
`default_nettype wire

// ==== dfc_filter_config.sv ====
// Decimation filter core with its configuration registers.
`timescale 1ns/1ns
`default_nettype none
`include "dfc_defs.svh"
module dfc_filter_config
  import dfc_pkg::*;
#(
  parameter int SW = `DFC_SAMPLE_W,
  parameter int CW = `DFC_COEF_W,
  parameter int OW = `DFC_OUT_W,
  parameter int TAPS = `DFC_TAPS_EVEN,
  parameter int DEPTH = `DFC_FIFO_DEPTH
) (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic reset_n,
  input wire logic clk_en,
  // Serial configuration pins
  input wire logic sclk,
  input wire logic sdata,
  input wire logic sen_n,
  // Controls from the rest of the processing chain
  input wire logic low_latency,
  input wire logic [TAPS-1:0][CW-1:0] user_coef,
  // Sample input
  input wire logic smp_valid,
  input wire logic [SW-1:0] smp_data,
  output logic smp_ready,
  // Filtered output
  output logic out_valid,
  output logic [OW-1:0] out_data,
  // Status
  output logic offset_corr_en,
  output logic coef_user_active,
  output logic [3:0] decim_factor
);
  localparam int AW = SW + CW + 5;
  localparam int PW = SW + CW;

  // ***************************************************************
  // State
  // ***************************************************************
  typedef struct packed {
    dfc_state_t st;
    logic [7:0] ctrl;
    logic [7:0] band;
    logic [TAPS-1:0][SW-1:0] hist;
    logic [4:0] tap;
    logic [3:0] dec_cnt;
    logic signed [AW-1:0] acc;
    logic [OW-1:0] out_data;
    logic out_valid;
  } dfc_core_t;

  dfc_core_t r;
  dfc_core_t next_r;

  dfc_cfg_if cfg ();
  dfc_fifo_if #(.W(SW)) q ();

  logic pop;
  logic [CW-1:0] cur_coef;
  logic signed [PW-1:0] prod;
  logic [3:0] factor;

  // ***************************************************************
  // Submodules
  // ***************************************************************
  dfc_serial_cfg u_serial (
    .ref_clk (ref_clk),
    .reset_n (reset_n),
    .clk_en (clk_en),
    .sclk (sclk),
    .sdata (sdata),
    .sen_n (sen_n),
    .cfg (cfg.src)
  );

  dfc_fifo #(.W(SW), .DEPTH(DEPTH)) u_fifo (
    .ref_clk (ref_clk),
    .reset_n (reset_n),
    .clk_en (clk_en),
    .q (q.fifo)
  );

  assign q.in_valid = smp_valid;
  assign q.in_data = smp_data;
  assign smp_ready = q.in_ready;
  // The engine takes a sample only when idle, so a long filter run
  // stalls the queue and pushes back onto the sample source.
  assign q.out_ready = (r.st == st_idle);
  assign pop = q.out_valid && q.out_ready;

  // ***************************************************************
  // Decoding
  // ***************************************************************
  function automatic logic [3:0] dec_factor(input logic [7:0] c);
    if (!c[`DFC_DECEN_BIT]) begin
      return 4'h1;
    end
    case (c[2:0])
      `DFC_RATIO_DEC2: return 4'h2;
      `DFC_RATIO_DEC4: return 4'h4;
      `DFC_RATIO_DEC8: return 4'h8;
      default: return 4'h1;
    endcase
  endfunction

  function automatic logic use_user(input logic [7:0] c);
    return c[`DFC_CSEL_BIT] ||
           c[2:0] == `DFC_RATIO_DEC8 ||
           dec_factor(c) == 4'h1;
  endfunction

  function automatic logic [4:0] tap_count(input logic [7:0] c);
    return c[`DFC_ODD_BIT] ? 5'(`DFC_TAPS_ODD) : 5'(`DFC_TAPS_EVEN);
  endfunction

  // Unused band codes fall back to the low-pass set.
  function automatic logic [CW-1:0] builtin(input logic [4:0] k,
                                           input logic [7:0] c,
                                           input logic [1:0] b);
    if (c[2:0] == `DFC_RATIO_DEC4) begin
      return CW'(`DFC_BI_LP4);
    end
    if (b == `DFC_BAND_HP && k[0]) begin
      return CW'(-`DFC_BI_LP2);
    end
    return CW'(`DFC_BI_LP2);
  endfunction

  always_comb begin
    cur_coef = '0;
    if (r.tap < 5'(TAPS)) begin
      cur_coef = use_user(r.ctrl) ? user_coef[r.tap]
                                  : builtin(r.tap, r.ctrl, r.band[1:0]);
    end
  end

  // The product has a process of its own so that no unsigned operand
  // beside it can turn the multiply unsigned.
  always_comb begin
    prod = '0;
    if (r.tap < 5'(TAPS)) begin
      prod = $signed(r.hist[r.tap]) * $signed(cur_coef);
    end
  end

  assign factor = dec_factor(r.ctrl);

  // ***************************************************************
  // Next state
  // ***************************************************************
  // A configuration write during a filter run takes effect at once;
  // software should change the set-up only while samples are idle.
  always_comb begin
    next_r = r;
    next_r.out_valid = 1'b0;
    if (cfg.wr && cfg.addr == `DFC_ADDR_CTRL) begin
      next_r.ctrl = cfg.data & `DFC_CTRL_MASK;
    end
    if (cfg.wr && cfg.addr == `DFC_ADDR_BAND) begin
      next_r.band = cfg.data & `DFC_BAND_MASK;
    end
    unique case (r.st)
      st_idle: begin
        if (pop) begin
          next_r.hist = {r.hist[TAPS-2:0], q.out_data};
          if (low_latency) begin
            next_r.out_data = OW'($signed(q.out_data));
            next_r.out_valid = 1'b1;
            next_r.dec_cnt = '0;
          end else if (r.dec_cnt + 4'h1 >= factor) begin
            next_r.dec_cnt = '0;
            next_r.st = st_mac;
            next_r.tap = '0;
            next_r.acc = '0;
          end else begin
            next_r.dec_cnt = r.dec_cnt + 4'h1;
          end
        end
      end
      st_mac: begin
        next_r.acc = r.acc + AW'(prod);
        next_r.tap = r.tap + 5'h1;
        if (r.tap + 5'h1 >= tap_count(r.ctrl)) begin
          next_r.st = st_out;
        end
      end
      st_out: begin
        next_r.out_data = r.acc[AW-1 -: OW];
        next_r.out_valid = 1'b1;
        next_r.st = st_idle;
      end
      default: next_r.st = st_idle;
    endcase
  end

  always_ff @(posedge ref_clk) begin
    if (!reset_n) begin
      r <= '0;
      r.ctrl <= `DFC_CTRL_RST;
      r.band <= `DFC_BAND_RST;
    end else if (clk_en) begin
      r <= next_r;
    end
  end

  // ***************************************************************
  // Outputs
  // ***************************************************************
  assign out_valid = r.out_valid;
  assign out_data = r.out_data;
  assign offset_corr_en = r.ctrl[`DFC_OFFEN_BIT];
  assign coef_user_active = use_user(r.ctrl);
  assign decim_factor = factor;

  // ***************************************************************
  // Assertions
  // ***************************************************************
  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (!reset_n || !clk_en);

  sequence s_wr_ctrl;
    cfg.wr && cfg.addr == `DFC_ADDR_CTRL;
  endsequence

  sequence s_wr_band;
    cfg.wr && cfg.addr == `DFC_ADDR_BAND;
  endsequence

  sequence s_decim_pop;
    pop && !low_latency && (r.dec_cnt + 4'h1 >= factor);
  endsequence

  sequence s_mac_end;
    (r.st == st_mac) ##1 (r.st == st_out);
  endsequence

  a_ctrl_write: assert property (
    s_wr_ctrl |=> r.ctrl == ($past(cfg.data) & `DFC_CTRL_MASK))
    else $error("Control register did not take the written value.");

  a_band_write: assert property (
    s_wr_band |=> r.band == ($past(cfg.data) & `DFC_BAND_MASK))
    else $error("Band register did not take the written value.");

  a_ratio_decode: assert property (
    r.ctrl[`DFC_DECEN_BIT] && r.ctrl[2:1] == 2'h0 |->
    factor == (r.ctrl[0] ? 4'h4 : 4'h2))
    else $error("Ratio codes 000 and 001 give the wrong factor.");

  a_decim_start: assert property (
    s_decim_pop |=> r.st == st_mac && r.tap == 5'h0 && r.dec_cnt == 4'h0)
    else $error("Filter run did not start on the decimated sample.");

  a_dec8_user: assert property (
    r.ctrl[2:0] == `DFC_RATIO_DEC8 |-> coef_user_active &&
    (r.st != st_mac || r.tap >= 5'(TAPS) || cur_coef == user_coef[r.tap]))
    else $error("Decimate by eight used built-in coefficients.");

  a_nodec_user: assert property (
    factor == 4'h1 |-> coef_user_active &&
    (r.st != st_mac || r.tap >= 5'(TAPS) || cur_coef == user_coef[r.tap]))
    else $error("Built-in coefficients used without decimation.");

  a_tap_count: assert property (
    s_mac_end ##0 $stable(r.ctrl) |->
    r.tap == (r.ctrl[`DFC_ODD_BIT] ? 5'(`DFC_TAPS_ODD)
                                   : 5'(`DFC_TAPS_EVEN)))
    else $error("Filter run used the wrong number of taps.");

  a_out_after_run: assert property (
    s_mac_end |=> r.out_valid && r.out_data == $past(r.acc[AW-1 -: OW]))
    else $error("Filter result was not presented after the run.");

  a_user_source: assert property (
    r.st == st_mac && r.ctrl[`DFC_CSEL_BIT] && r.tap < 5'(TAPS) |->
    cur_coef == user_coef[r.tap])
    else $error("User coefficient not applied when selected.");

  a_band_high: assert property (
    r.st == st_mac && !coef_user_active && r.tap[0] &&
    r.ctrl[2:0] == `DFC_RATIO_DEC2 && r.band[1:0] == `DFC_BAND_HP |->
    cur_coef == CW'(-`DFC_BI_LP2))
    else $error("High-pass set not applied for band 01.");

  a_band_low2: assert property (
    r.st == st_mac && !coef_user_active &&
    r.ctrl[2:0] == `DFC_RATIO_DEC2 && r.band[1:0] != `DFC_BAND_HP |->
    cur_coef == CW'(`DFC_BI_LP2))
    else $error("Low-pass set not applied with decimate by two.");

  a_band_low4: assert property (
    r.st == st_mac && !coef_user_active &&
    r.ctrl[2:0] == `DFC_RATIO_DEC4 |-> cur_coef == CW'(`DFC_BI_LP4))
    else $error("Low-pass set not applied for decimate by four.");

  a_bypass_path: assert property (
    pop && low_latency |=>
    r.out_valid && r.st == st_idle &&
    r.out_data == OW'($signed($past(q.out_data))))
    else $error("Low latency did not bypass the filter.");

  a_bypass_idle: assert property (
    low_latency && r.st == st_idle |=> r.st == st_idle)
    else $error("A filter run started while the filter was bypassed.");
endmodule
`default_nettype wire

// ==== dfc_host.sv ====
// Host model that writes configuration registers over the serial pins.
`timescale 1ns/1ns
`default_nettype none
module dfc_host (
  // Clock
  input wire logic ref_clk,
  // Serial pins
  output logic sclk,
  output logic sdata,
  output logic sen_n
);
  // Serial clock stands still low between frames; sdata rests low and
  // sen_n high.
  initial begin
    sclk = 1'b0;
    sdata = 1'b0;
    sen_n = 1'b1;
  end

  task automatic tick(input int n);
    repeat (n) @(posedge ref_clk);
    #1;
  endtask

  task automatic write_reg(input logic [7:0] a, input logic [7:0] d);
    logic [15:0] f;
    f = {a, d & ((a == 8'h1D) ? 8'h03 : 8'hBF)};
    sen_n = 1'b0;
    for (int i = 15; i >= 0; i--) begin
      sdata = f[i];
      tick(3);
      sclk = 1'b1;
      tick(3);
      sclk = 1'b0;
    end
    tick(2);
    sen_n = 1'b1;
    sdata = 1'b0;
    tick(8);
  endtask
endmodule
`default_nettype wire

// ==== dfc_filter_config_test.sv ====
// Self-checking bench for the decimation filter configuration block.
`timescale 1ns/1ns
`default_nettype none
`include "dfc_defs.svh"
module dfc_filter_config_test;
  logic ref_clk = 1'b0;
  logic reset_n = 1'b0;
  logic clk_en = 1'b1;
  logic [31:0] mon_want;
  logic low_latency = 1'b0;
  logic smp_valid = 1'b0;
  logic [10:0] smp_data = 11'h000;
  logic [23:0][11:0] coef = '0;
  wire logic sclk;
  wire logic sdata;
  wire logic sen_n;
  logic smp_ready;
  logic out_valid;
  logic [15:0] out_data;
  logic offset_corr_en;
  logic coef_user_active;
  logic [3:0] decim_factor;
  logic signed [11:0] mc [24];
  logic signed [10:0] hist [24];
  logic [15:0] exp_q [$];
  logic byp = 1'b0;
  logic saw_full = 1'b0;
  logic eu;
  int fac;
  int ntap;
  int cnt;
  int n_mismatch = 0;
  int cmp_count = 0;
  logic [7:0] t_ctrl [9] = '{8'h10, 8'h10, 8'h11, 8'h31,
                             8'h13, 8'h12, 8'h38, 8'h90, 8'h0C};
  logic [7:0] t_band [9] = '{8'h00, 8'h01, 8'h00, 8'h00,
                             8'h00, 8'h00, 8'h00, 8'h02, 8'h00};
  int t_fac [9] = '{2, 2, 4, 4, 8, 1, 2, 2, 1};

  always #20 ref_clk = ~ref_clk;

  dfc_host u_host (
    .ref_clk(ref_clk),
    .sclk(sclk),
    .sdata(sdata),
    .sen_n(sen_n)
  );

  dfc_filter_config u_dut (
    .ref_clk(ref_clk),
    .reset_n(reset_n),
    .clk_en(clk_en),
    .sclk(sclk),
    .sdata(sdata),
    .sen_n(sen_n),
    .low_latency(low_latency),
    .user_coef(coef),
    .smp_valid(smp_valid),
    .smp_data(smp_data),
    .smp_ready(smp_ready),
    .out_valid(out_valid),
    .out_data(out_data),
    .offset_corr_en(offset_corr_en),
    .coef_user_active(coef_user_active),
    .decim_factor(decim_factor)
  );

  // ********************
  // Checking and verdict
  // ********************
  task automatic check(input logic [31:0] seen, input logic [31:0] want);
    cmp_count++;
    if (seen !== want) begin
      n_mismatch++;
      $display("MISMATCH t=%0t seen=%h want=%h", $time, seen, want);
    end
  endtask

  task automatic give_verdict();
    $display("Comparisons %0d, mismatches %0d", cmp_count, n_mismatch);
    if (n_mismatch == 0 && cmp_count > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask

  // An output with nothing queued meets a value it can never equal.
  // A pulse held by a frozen clock enable counts once, when it is taken.
  always @(negedge ref_clk) begin
    if (out_valid === 1'b1 && clk_en === 1'b1) begin
      mon_want = (exp_q.size() > 0) ? exp_q.pop_front() : 32'hDEAD0000;
      check(out_data, mon_want);
    end
  end

  initial begin
    #(40 * 60000);
    n_mismatch++;
    give_verdict();
  end

  // ********************
  // Drivers and model
  // ********************
  task automatic do_reset();
    reset_n = 1'b0;
    repeat (2) @(posedge ref_clk);
    #1;
    reset_n = 1'b1;
    cnt = 0;
    foreach (hist[k]) hist[k] = '0;
    repeat (3) @(posedge ref_clk);
    #1;
  endtask

  task automatic push_smp(input logic [10:0] v);
    longint acc;
    smp_valid = 1'b1;
    smp_data = v;
    while (smp_ready !== 1'b1) begin
      saw_full = 1'b1;
      @(posedge ref_clk);
      #1;
    end
    @(posedge ref_clk);
    #1;
    if (byp) begin
      exp_q.push_back({{5{v[10]}}, v});
    end else begin
      for (int k = 23; k > 0; k--) hist[k] = hist[k-1];
      hist[0] = v;
      cnt++;
      if (cnt == fac) begin
        cnt = 0;
        acc = 0;
        for (int k = 0; k < ntap; k++) acc += mc[k] * hist[k];
        exp_q.push_back(acc[27:12]);
      end
    end
  endtask

  task automatic drain(input bit frz);
    int n;
    logic [15:0] held;
    n = 0;
    smp_valid = 1'b0;
    // A low clock enable must hold every result where it stands.
    if (frz) begin
      clk_en = 1'b0;
      held = out_data;
      repeat (50) @(posedge ref_clk);
      #1;
      check(out_data, held);
      clk_en = 1'b1;
    end
    while (exp_q.size() != 0 && n < 3000) begin
      @(posedge ref_clk);
      n++;
    end
    repeat (4) @(posedge ref_clk);
    #1;
    check(exp_q.size(), 0);
  endtask

  initial begin
    void'($urandom(32'h8005BCB4));
    foreach (coef[k]) coef[k] = 12'($urandom);
    // The last tap is made large, but with only 16 samples after each reset it only ever meets zero history.
    coef[23] = 12'h7FF;
    do_reset();
    check(decim_factor, 1);
    check(coef_user_active, 1);
    check(offset_corr_en, 0);
    for (int s = 0; s < 9; s++) begin
      do_reset();
      u_host.write_reg(8'h1B, t_ctrl[s]);
      u_host.write_reg(8'h1D, t_band[s] | 8'hFC);
      u_host.write_reg(8'h1C, 8'hFF);
      eu = t_ctrl[s][5] | t_ctrl[s][2] | t_ctrl[s][1] | ~t_ctrl[s][4];
      check(decim_factor, t_fac[s]);
      check(coef_user_active, eu);
      check(offset_corr_en, t_ctrl[s][7]);
      fac = t_fac[s];
      ntap = t_ctrl[s][3] ? 23 : 24;
      foreach (mc[k]) begin
        if (eu) mc[k] = coef[k];
        else if (fac == 4) mc[k] = `DFC_BI_LP4;
        else if (t_band[s] == 8'h01 && k[0]) mc[k] = -`DFC_BI_LP2;
        else mc[k] = `DFC_BI_LP2;
      end
      saw_full = 1'b0;
      for (int i = 0; i < 16; i++) push_smp(11'($urandom));
      if (s == 5) check(saw_full, 1);
      drain(s == 5);
    end
    do_reset();
    u_host.write_reg(8'h1B, 8'h10);
    low_latency = 1'b1;
    byp = 1'b1;
    for (int i = 0; i < 12; i++) push_smp(11'($urandom));
    drain(1'b0);
    give_verdict();
  end
endmodule
`default_nettype wire
